//--- shared/lcdtxt_pkg.sv
// Function
// - Start cell column 1-12, row 1-4
// - Display length limited to 1-12 cells
// - Stored string holds at most 63 characters
// - Flash period 1-255 units of 100 ms
// - Scroll step interval 0-255 units of 100 ms
// - Bargraph signed min/max bounds, length 1-12
// - Select one data source to show
// - Date mm/dd/yyyy, time hh:mm
// - Same cell: higher block number wins
// - Strings wrap onto next row down
// - Values, date, time never wrap rows
// - Values refresh on screen as they change
// - Shown only while enable input active
// - Neither flash nor scroll: static string
package lcdtxt_pkg;

  // ==========================================
  // Geometry and timing
  localparam int COLS        = 12;
  localparam int ROWS        = 4;
  localparam int CELLS       = COLS * ROWS;
  localparam int STR_MAX     = 63;
  localparam int TICK_MS     = 100;
  localparam int CLK_MHZ     = 100;
  localparam int TICK_CYCLES = TICK_MS * 1000 * CLK_MHZ;

  // ==========================================
  // Register offsets
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_POS    = 12'h004;
  localparam logic [11:0] OFS_TIME   = 12'h008;
  localparam logic [11:0] OFS_BAR    = 12'h00c;
  localparam logic [11:0] OFS_STRLEN = 12'h010;
  localparam logic [11:0] OFS_STAT   = 12'h014;
  localparam logic [3:0]  OFS_STR_HI = 4'h1;

  // ==========================================
  // Field positions
  localparam int CTRL_SRC_LSB    = 0;
  localparam int CTRL_MODE_LSB   = 4;
  localparam int CTRL_NUM_LSB    = 8;
  localparam int POS_X_LSB       = 0;
  localparam int POS_Y_LSB       = 8;
  localparam int POS_LEN_LSB     = 16;
  localparam int TIME_FLASH_LSB  = 0;
  localparam int TIME_SCROLL_LSB = 8;
  localparam int BAR_MIN_LSB     = 0;
  localparam int BAR_MAX_LSB     = 16;

  // ==========================================
  // Reset values
  localparam logic [3:0] RST_X      = 4'h1;
  localparam logic [2:0] RST_Y      = 3'h1;
  localparam logic [3:0] RST_LEN    = 4'h1;
  localparam logic [7:0] RST_FLASH  = 8'h01;
  localparam logic [7:0] RST_SCROLL = 8'h00;

  // ==========================================
  // Field widths and glyphs
  localparam logic [3:0] VAL_W  = 4'h6;
  localparam logic [3:0] DATE_W = 4'ha;
  localparam logic [3:0] TIME_W = 4'h5;
  localparam logic [3:0] TS_W   = 4'h3;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_BAR   = 8'hff;
  localparam logic [7:0] CH_MINUS = 8'h2d;
  localparam logic [7:0] CH_SLASH = 8'h2f;
  localparam logic [7:0] CH_COLON = 8'h3a;
  localparam logic [7:0] CH_ZERO  = 8'h30;
  localparam logic [7:0] CH_O     = 8'h4f;
  localparam logic [7:0] CH_N     = 8'h4e;
  localparam logic [7:0] CH_F     = 8'h46;

  typedef enum logic [2:0] {
    SRC_NONE, SRC_STRING, SRC_ANA_VAL, SRC_ANA_BAR,
    SRC_FB_VAL, SRC_TS, SRC_DATE, SRC_TIME
  } lcdtxt_src_t;

  typedef enum logic [1:0] {MODE_FIXED, MODE_FLASH, MODE_SCROLL} lcdtxt_mode_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } lcdtxt_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } lcdtxt_apb_rsp_t;

  typedef struct packed {
    logic [3:0]  month;
    logic [4:0]  day;
    logic [13:0] year;
    logic [4:0]  hour;
    logic [5:0]  minute;
  } lcdtxt_cal_t;

  typedef struct packed {
    logic       wr;
    logic       free;
    logic [5:0] addr;
    logic [3:0] num;
    logic [7:0] ch;
  } lcdtxt_cell_wr_t;

endpackage : lcdtxt_pkg

//--- rtl/lcdtxt_tick.sv
module lcdtxt_tick #(
  parameter int unsigned TICK_CYC = lcdtxt_pkg::TICK_CYCLES
) (
  input  wire logic ref_clk_in,
  input  wire logic arst_n_in,
  input  wire logic restart_in,
  output logic      tick_out
);
  import lcdtxt_pkg::*;

  logic [23:0] cnt;
  wire         last = (cnt == 24'(TICK_CYC - 1));

  // ==========================================
  // 100 ms timebase, realigned on enable
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt      <= 24'h000000;
      tick_out <= 1'b0;
    end else if (restart_in) begin
      cnt      <= 24'h000000;
      tick_out <= 1'b0;
    end else begin
      cnt      <= last ? 24'h000000 : cnt + 24'h000001;
      tick_out <= last;
    end
  end

endmodule : lcdtxt_tick

//--- rtl/lcdtxt_block.sv
module lcdtxt_block #(
  parameter int unsigned TICK_CYC = lcdtxt_pkg::TICK_CYCLES
) (
  input  wire logic                        ref_clk_in,
  input  wire logic                        arst_n_in,
  input  wire lcdtxt_pkg::lcdtxt_apb_req_t apb_req_in,
  output lcdtxt_pkg::lcdtxt_apb_rsp_t      apb_rsp_out,
  input  wire logic                        enable_in,
  input  wire logic [15:0]                 analog_value_in,
  input  wire logic [15:0]                 fb_value_in,
  input  wire logic                        time_switch_info_in,
  input  wire lcdtxt_pkg::lcdtxt_cal_t     cal_in,
  input  wire lcdtxt_pkg::lcdtxt_cell_wr_t other_wr_in,
  input  wire logic [5:0]                  scan_addr_in,
  output logic [7:0]                       scan_char_out
);
  import lcdtxt_pkg::*;

  // ==========================================
  // Helpers
  function automatic logic [3:0] clamp4(input logic [7:0] v, input logic [3:0] hi);
    if (v == 8'h00) return 4'h1;
    if (v > {4'h0, hi}) return hi;
    return v[3:0];
  endfunction : clamp4

  function automatic logic [3:0] dec_digit(input logic [15:0] v, input int p);
    logic [15:0] t;
    t = v;
    for (int i = 0; i < 5; i++) begin
      if (i < p) t = t / 16'd10;
    end
    return 4'(t % 16'd10);
  endfunction : dec_digit

  function automatic logic [7:0] dig_ch(input logic [15:0] v, input int p);
    return CH_ZERO + {4'h0, dec_digit(v, p)};
  endfunction : dig_ch

  function automatic logic [15:0] pow10(input int p);
    logic [15:0] r;
    r = 16'h0001;
    for (int i = 0; i < 4; i++) begin
      if (i < p) r = r * 16'd10;
    end
    return r;
  endfunction : pow10

  function automatic logic [3:0] min4(input logic [3:0] a, input logic [3:0] b);
    return (a < b) ? a : b;
  endfunction : min4

  // ==========================================
  // Configuration registers
  lcdtxt_src_t  src;
  lcdtxt_mode_t mode;
  logic [3:0]   blk_num;
  logic [3:0]   pos_x;
  logic [2:0]   pos_y;
  logic [3:0]   disp_len;
  logic [7:0]   flash_per;
  logic [7:0]   scroll_ivl;
  logic [15:0]  bar_min;
  logic [15:0]  bar_max;
  logic [5:0]   str_len;
  logic [7:0]   str_mem [STR_MAX];

  // ==========================================
  // APB slave, zero wait states
  wire [11:0] pa    = apb_req_in.paddr;
  wire [31:0] wd    = apb_req_in.pwdata;
  wire        setup = apb_req_in.psel & ~apb_req_in.penable;
  wire        acc_w = apb_req_in.psel & apb_req_in.penable & apb_req_in.pwrite
                      & apb_rsp_out.pready;
  wire        s_ctrl = (pa == OFS_CTRL);
  wire        s_pos  = (pa == OFS_POS);
  wire        s_time = (pa == OFS_TIME);
  wire        s_bar  = (pa == OFS_BAR);
  wire        s_slen = (pa == OFS_STRLEN);
  wire        s_stat = (pa == OFS_STAT);
  wire        s_str  = (pa[11:8] == OFS_STR_HI) && (pa[7:2] != 6'h3f) && (pa[1:0] == 2'h0);
  wire        mapped = s_ctrl | s_pos | s_time | s_bar | s_slen | s_stat | s_str;
  wire [5:0]  str_wi = pa[7:2];
  wire [1:0]  wmode  = wd[CTRL_MODE_LSB +: 2];

  logic       flash_on;
  logic [5:0] scroll_pos;
  logic [31:0] next_prdata;

  always_comb begin
    next_prdata = 32'h00000000;
    if (s_ctrl) next_prdata = {20'h00000, blk_num, 2'h0, mode, 1'b0, src};
    if (s_pos)  next_prdata = {12'h000, disp_len, 5'h00, pos_y, 4'h0, pos_x};
    if (s_time) next_prdata = {16'h0000, scroll_ivl, flash_per};
    if (s_bar)  next_prdata = {bar_max, bar_min};
    if (s_slen) next_prdata = {26'h0000000, str_len};
    if (s_stat) next_prdata = {16'h0000, 2'h0, scroll_pos, 6'h00, flash_on, enable_in};
    if (s_str)  next_prdata = {24'h000000, str_mem[str_wi]};
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      apb_rsp_out <= '0;
    end else begin
      apb_rsp_out.pready  <= setup;
      apb_rsp_out.pslverr <= setup & ~mapped;
      apb_rsp_out.prdata  <= setup ? next_prdata : 32'h00000000;
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      src        <= SRC_NONE;
      mode       <= MODE_FIXED;
      blk_num    <= 4'h0;
      pos_x      <= RST_X;
      pos_y      <= RST_Y;
      disp_len   <= RST_LEN;
      flash_per  <= RST_FLASH;
      scroll_ivl <= RST_SCROLL;
      bar_min    <= 16'h0000;
      bar_max    <= 16'h0000;
      str_len    <= 6'h00;
    end else if (acc_w) begin
      if (s_ctrl) begin
        src     <= lcdtxt_src_t'(wd[CTRL_SRC_LSB +: 3]);
        mode    <= (wmode == 2'h3) ? MODE_FIXED : lcdtxt_mode_t'(wmode);
        blk_num <= wd[CTRL_NUM_LSB +: 4];
      end
      if (s_pos) begin
        pos_x    <= clamp4(wd[POS_X_LSB +: 8], 4'(COLS));
        pos_y    <= 3'(clamp4({5'h00, wd[POS_Y_LSB +: 3]}, 4'(ROWS)));
        disp_len <= clamp4(wd[POS_LEN_LSB +: 8], 4'(COLS));
      end
      if (s_time) begin
        flash_per  <= (wd[TIME_FLASH_LSB +: 8] == 8'h00) ? 8'h01
                                                          : wd[TIME_FLASH_LSB +: 8];
        scroll_ivl <= wd[TIME_SCROLL_LSB +: 8];
      end
      if (s_bar) begin
        bar_min <= wd[BAR_MIN_LSB +: 16];
        bar_max <= wd[BAR_MAX_LSB +: 16];
      end
      if (s_slen) str_len <= (wd > 32'(STR_MAX)) ? 6'(STR_MAX) : wd[5:0];
    end
  end

  // No reset on the text store: software loads it before use
  always_ff @(posedge ref_clk_in) begin
    if (acc_w && s_str) str_mem[str_wi] <= wd[7:0];
  end

  // ==========================================
  // Flash and scroll timing
  logic       tick;
  logic       en_q;
  logic [7:0] flash_cnt;
  logic [7:0] scroll_cnt;
  wire        en_rise = enable_in & ~en_q;
  wire        flash_hit = (flash_cnt + 8'h01 >= flash_per);
  wire        scroll_hit = (scroll_cnt + 8'h01 >= scroll_ivl);
  wire [5:0]  pos_inc = scroll_pos + 6'h01;

  lcdtxt_tick #(.TICK_CYC(TICK_CYC)) u_tick (
    .ref_clk_in (ref_clk_in),
    .arst_n_in  (arst_n_in),
    .restart_in (en_rise),
    .tick_out   (tick)
  );

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      en_q       <= 1'b0;
      flash_on   <= 1'b1;
      flash_cnt  <= 8'h00;
      scroll_cnt <= 8'h00;
      scroll_pos <= 6'h00;
    end else begin
      en_q <= enable_in;
      if (en_rise) begin
        flash_on   <= 1'b1;
        flash_cnt  <= 8'h00;
        scroll_cnt <= 8'h00;
        scroll_pos <= 6'h00;
      end else if (tick) begin
        flash_cnt  <= flash_hit ? 8'h00 : flash_cnt + 8'h01;
        if (flash_hit && mode == MODE_FLASH) flash_on <= ~flash_on;
        scroll_cnt <= scroll_hit ? 8'h00 : scroll_cnt + 8'h01;
        // Interval zero holds the text still
        if (scroll_hit && mode == MODE_SCROLL && scroll_ivl != 8'h00) begin
          scroll_pos <= (pos_inc >= str_len) ? 6'h00 : pos_inc;
        end
      end
    end
  end

  // ==========================================
  // Bargraph fill, one cycle behind the input
  logic [3:0]  bar_fill;
  wire signed [16:0] sv   = {analog_value_in[15], analog_value_in};
  wire signed [16:0] smin = {bar_min[15], bar_min};
  wire signed [16:0] smax = {bar_max[15], bar_max};
  wire [16:0]  span = 17'(smax - smin);
  wire [16:0]  offs = 17'(sv - smin);
  wire [20:0]  prod = 21'(offs) * 21'(disp_len);
  wire [3:0]  ratio = 4'(prod / {4'h0, span});

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      bar_fill <= 4'h0;
    end else if (sv <= smin) begin
      bar_fill <= 4'h0;
    end else if (sv >= smax) begin
      bar_fill <= disp_len;
    end else begin
      bar_fill <= ratio;
    end
  end

  // ==========================================
  // Cell sweep and own rendering
  logic [5:0] sweep;
  wire [5:0]  start = 6'(pos_y - 3'h1) * 6'(COLS) + 6'(pos_x - 4'h1);
  wire [5:0]  jj    = sweep - start;
  wire [2:0]  row_c = 3'(sweep / 6'(COLS));
  wire        is_str = (src == SRC_STRING);
  wire        in_row = (row_c == pos_y - 3'h1);
  wire [6:0]  sidx_s = 7'(jj) + 7'(scroll_pos);
  wire [5:0]  sidx  = (mode == MODE_SCROLL && str_len != 6'h00)
                      ? 6'(sidx_s % 7'(str_len)) : jj;
  wire        v_neg = (src == SRC_FB_VAL) ? fb_value_in[15] : analog_value_in[15];
  wire [15:0] v_raw = (src == SRC_FB_VAL) ? fb_value_in : analog_value_in;
  wire [15:0] v_mag = v_neg ? 16'(-v_raw) : v_raw;
  wire [15:0] mon   = {12'h000, cal_in.month};
  wire [15:0] day   = {11'h000, cal_in.day};
  wire [15:0] yr    = {2'h0, cal_in.year};
  wire [15:0] hr    = {11'h000, cal_in.hour};
  wire [15:0] mn    = {10'h000, cal_in.minute};
  wire        v_lead = (jj > 6'h0) && (jj < 6'h5) && (v_mag < pow10(5 - int'(jj)));

  logic [3:0] fw;
  logic [5:0] span_c;
  logic [7:0] own_ch;

  always_comb begin
    fw = 4'h0;
    unique case (src)
      SRC_ANA_VAL, SRC_FB_VAL: fw = VAL_W;
      SRC_ANA_BAR:             fw = disp_len;
      SRC_TS:                  fw = TS_W;
      SRC_DATE:                fw = DATE_W;
      SRC_TIME:                fw = TIME_W;
      SRC_NONE, SRC_STRING:    fw = 4'h0;
    endcase
    // Strings run their full length across rows; scroll uses a window
    span_c = (mode == MODE_SCROLL) ? {2'h0, disp_len} : str_len;
    if (!is_str) span_c = {2'h0, min4(fw, disp_len)};
  end

  wire own_cov = enable_in && (sweep >= start) && (jj < span_c) && (src != SRC_NONE)
                 && (is_str || in_row);

  always_comb begin
    own_ch = CH_SPACE;
    unique case (src)
      SRC_STRING:  own_ch = (mode == MODE_FLASH && !flash_on) ? CH_SPACE
                                                              : str_mem[sidx];
      SRC_ANA_VAL, SRC_FB_VAL: begin
        if (jj == 6'h0) own_ch = v_neg ? CH_MINUS : CH_SPACE;
        else own_ch = v_lead ? CH_SPACE : dig_ch(v_mag, 5 - int'(jj));
      end
      SRC_ANA_BAR: own_ch = (jj < {2'h0, bar_fill}) ? CH_BAR : CH_SPACE;
      SRC_TS:      own_ch = (jj == 6'h0) ? CH_O
                          : (time_switch_info_in ? ((jj == 6'h1) ? CH_N : CH_SPACE) : CH_F);
      SRC_DATE: begin
        unique case (jj)
          6'h0:       own_ch = dig_ch(mon, 1);
          6'h1:       own_ch = dig_ch(mon, 0);
          6'h2, 6'h5: own_ch = CH_SLASH;
          6'h3:       own_ch = dig_ch(day, 1);
          6'h4:       own_ch = dig_ch(day, 0);
          6'h6:       own_ch = dig_ch(yr, 3);
          6'h7:       own_ch = dig_ch(yr, 2);
          6'h8:       own_ch = dig_ch(yr, 1);
          default:    own_ch = dig_ch(yr, 0);
        endcase
      end
      SRC_TIME: begin
        unique case (jj)
          6'h0:    own_ch = dig_ch(hr, 1);
          6'h1:    own_ch = dig_ch(hr, 0);
          6'h2:    own_ch = CH_COLON;
          6'h3:    own_ch = dig_ch(mn, 1);
          default: own_ch = dig_ch(mn, 0);
        endcase
      end
      SRC_NONE:    own_ch = CH_SPACE;
    endcase
  end

  // ==========================================
  // Shared screen with per-cell owner
  logic [7:0] scr_ch   [CELLS];
  logic [3:0] scr_num  [CELLS];
  logic       scr_used [CELLS];

  wire [5:0] oa     = other_wr_in.addr;
  wire       oa_ok  = (oa < 6'(CELLS));
  wire       oth_wr = other_wr_in.wr && oa_ok
                      && (!scr_used[oa] || other_wr_in.num >= scr_num[oa]);
  wire       oth_fr = other_wr_in.free && oa_ok && scr_used[oa]
                      && (scr_num[oa] == other_wr_in.num);
  wire       clash  = oth_wr && (oa == sweep) && (other_wr_in.num > blk_num);
  wire       own_wr = own_cov && !clash
                      && (!scr_used[sweep] || blk_num >= scr_num[sweep]);
  wire       own_fr = !own_cov && scr_used[sweep] && (scr_num[sweep] == blk_num);

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sweep         <= 6'h00;
      scan_char_out <= CH_SPACE;
      for (int i = 0; i < CELLS; i++) begin
        scr_ch[i]   <= CH_SPACE;
        scr_num[i]  <= 4'h0;
        scr_used[i] <= 1'b0;
      end
    end else begin
      // Continuous repaint keeps live values current
      sweep <= (sweep == 6'(CELLS - 1)) ? 6'h00 : sweep + 6'h01;
      scan_char_out <= (scan_addr_in < 6'(CELLS)) ? scr_ch[scan_addr_in] : CH_SPACE;
      if (own_wr) begin
        scr_ch[sweep]   <= own_ch;
        scr_num[sweep]  <= blk_num;
        scr_used[sweep] <= 1'b1;
      end else if (own_fr) begin
        scr_ch[sweep]   <= CH_SPACE;
        scr_used[sweep] <= 1'b0;
      end
      if (oth_wr && !(own_wr && oa == sweep)) begin
        scr_ch[oa]   <= other_wr_in.ch;
        scr_num[oa]  <= other_wr_in.num;
        scr_used[oa] <= 1'b1;
      end else if (oth_fr && oa != sweep) begin
        scr_ch[oa]   <= CH_SPACE;
        scr_used[oa] <= 1'b0;
      end
    end
  end

  // ==========================================
  // Checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);

  sequence s_rise_then_quiet;
    en_rise ##1 !tick [*2];
  endsequence

  property p_pos_range;
    (pos_x >= 4'h1) && (pos_x <= 4'(COLS)) && (pos_y >= 3'h1) && (pos_y <= 3'(ROWS));
  endproperty
  a_pos_range: assert property (p_pos_range) else $error("position out of range");

  property p_len_range;
    (disp_len >= 4'h1) && (disp_len <= 4'(COLS));
  endproperty
  a_len_range: assert property (p_len_range) else $error("length out of range");

  property p_str_max;
    acc_w && s_slen |=> (str_len <= 6'(STR_MAX)) && (str_len != 6'h00 || $past(wd) == 32'h0);
  endproperty
  a_str_max: assert property (p_str_max) else $error("string length bad");

  property p_flash_tick;
    $changed(flash_on) && !$past(en_rise) |-> $past(tick) && $past(mode) == MODE_FLASH;
  endproperty
  a_flash_tick: assert property (p_flash_tick) else $error("flash off tick");

  property p_scroll_tick;
    $changed(scroll_pos) && !$past(en_rise) |-> $past(tick) && $past(scroll_ivl) != 8'h00;
  endproperty
  a_scroll_tick: assert property (p_scroll_tick) else $error("scroll off tick");

  property p_off_hidden;
    !enable_in && scr_used[sweep] && scr_num[sweep] == blk_num
      && !(other_wr_in.wr && oa == sweep) |=> scr_ch[$past(sweep)] == CH_SPACE;
  endproperty
  a_off_hidden: assert property (p_off_hidden) else $error("shown while off");

  property p_no_wrap;
    own_cov && !is_str |-> in_row && (jj < 6'(COLS));
  endproperty
  a_no_wrap: assert property (p_no_wrap) else $error("value wrapped");

  property p_bar_sat;
    ##1 ($past(sv) >= $past(smax)) && ($past(sv) > $past(smin)) |-> bar_fill == $past(disp_len);
  endproperty
  a_bar_sat: assert property (p_bar_sat) else $error("bar not full");

  property p_restart;
    en_rise |-> s_rise_then_quiet;
  endproperty
  a_restart: assert property (p_restart) else $error("tick not restarted");

  property p_prio;
    oth_wr && oa == sweep && other_wr_in.num > blk_num |=> scr_num[$past(oa)] == $past(other_wr_in.num);
  endproperty
  a_prio: assert property (p_prio) else $error("lower block won");

endmodule : lcdtxt_block

//--- tb/lcdtxt_panel_model.sv
module lcdtxt_panel_model (
  input  wire logic       ref_clk_in,
  input  wire logic       arst_n_in,
  input  wire logic [7:0] scan_char_in,
  output logic [5:0]      scan_addr_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Panel refresh: scan one cell a cycle, keep what came back
  logic [5:0] prev_addr;
  logic [7:0] screen [48];
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      scan_addr_out <= 6'h00;
      prev_addr     <= 6'h00;
    end else begin
      // Char answers the address of the previous cycle
      screen[prev_addr] <= scan_char_in;
      prev_addr         <= scan_addr_out;
      scan_addr_out     <= (scan_addr_out == 6'h2f) ? 6'h00 : scan_addr_out + 6'h01;
    end
  end
endmodule : lcdtxt_panel_model

//--- tb/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import lcdtxt_pkg::*;
  logic            clk = 1'b0;
  logic            arst_n = 1'b0;
  lcdtxt_apb_req_t req = '0;
  lcdtxt_apb_rsp_t rsp;
  logic            en = 1'b0;
  logic [15:0]     ana = 16'h0000;
  logic [15:0]     fbv = 16'h0000;
  logic            ts = 1'b0;
  lcdtxt_cal_t     cal = '0;
  lcdtxt_cell_wr_t ow = '0;
  logic [5:0]      saddr;
  logic [7:0]      schar;
  logic [31:0]     rd;
  logic            er;
  logic [31:0]     s = 32'hfe40;
  logic [7:0]      exp_s [12];
  int              mismatches = 0;
  int              n_tests = 0;
  int              v;
  always #5 clk = ~clk;
  lcdtxt_block #(.TICK_CYC(20)) lcdtxt_block_i (.ref_clk_in(clk), .arst_n_in(arst_n),
    .apb_req_in(req), .apb_rsp_out(rsp), .enable_in(en), .analog_value_in(ana),
    .fb_value_in(fbv), .time_switch_info_in(ts), .cal_in(cal), .other_wr_in(ow),
    .scan_addr_in(saddr), .scan_char_out(schar));
  lcdtxt_panel_model lcdtxt_panel_model_i (.ref_clk_in(clk), .arst_n_in(arst_n),
    .scan_char_in(schar), .scan_addr_out(saddr));
  // ==========================================
  // Helpers
  function automatic logic [31:0] rnd();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : rnd
  function automatic logic [7:0] dg(input int n, input int p);
    return CH_ZERO + 8'((n / p) % 10);
  endfunction : dg
  // Sign then five digits, leading zeros blank
  function automatic logic [7:0] val_ch(input logic signed [15:0] x, input int k);
    int m;
    int p;
    m = (x < 0) ? -int'(x) : int'(x);
    if (k == 0) return (x < 0) ? CH_MINUS : CH_SPACE;
    p = 10 ** (5 - k);
    return (m < p && k != 5) ? CH_SPACE : dg(m, p);
  endfunction : val_ch
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t word %h expected %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_cell(input int i, input logic [7:0] exp);
    n_tests++;
    if (lcdtxt_panel_model_i.screen[i] !== exp) begin
      mismatches++;
      $display("[FAIL] %0t cell %0d got %h expected %h", $time, i,
               lcdtxt_panel_model_i.screen[i], exp);
    end
  endtask : chk_cell
  task automatic chk_span(input int base, input int n);
    for (int i = 0; i < n; i++) chk_cell(base + i, exp_s[i]);
  endtask : chk_span
  // ==========================================
  // APB master, holds the request until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= w;
    req.paddr   <= a;
    req.pwdata  <= d;
    @(posedge clk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      end_sim();
    end
    rd = rsp.prdata;
    er = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
    // Idle edge: no strobe is assigned twice in one step
    @(posedge clk);
  endtask : apb
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk_word(rd, exp);
  endtask : rd_chk
  // Fixed mode, block number 5; repaint takes under 50 cycles
  task automatic show(input lcdtxt_src_t src, input logic [31:0] pos);
    apb(1'b1, OFS_POS, pos);
    apb(1'b1, OFS_CTRL, 32'h00000500 | {29'h0, src});
    repeat (120) @(posedge clk);
  endtask : show
  // ==========================================
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rd_chk(OFS_POS, 32'h00010101);
    rd_chk(OFS_TIME, 32'h00000001);
    apb(1'b0, 12'h1fc, 32'h0);
    chk_word({31'h0, er}, 32'h1);
    apb(1'b1, OFS_POS, 32'h000f0700);
    rd_chk(OFS_POS, 32'h000c0401);
    apb(1'b1, OFS_STRLEN, 32'd100);
    rd_chk(OFS_STRLEN, 32'd63);
    for (int i = 0; i < 4; i++) begin
      exp_s[i] = 8'h41 + 8'(i);
      apb(1'b1, 12'h100 + 12'(4 * i), {24'h0, exp_s[i]});
    end
    apb(1'b1, OFS_STRLEN, 32'd4);
    en <= 1'b1;
    show(SRC_STRING, 32'h000c010b);
    chk_span(10, 4);
    en <= 1'b0;
    repeat (120) @(posedge clk);
    chk_cell(11, CH_SPACE);
    en <= 1'b1;
    show(SRC_FB_VAL, 32'h000c010a);
    for (int t = 0; t < 3; t++) begin
      fbv <= (t == 0) ? 16'h8000 : 16'(rnd());
      repeat (120) @(posedge clk);
      for (int k = 0; k < 3; k++) chk_cell(9 + k, val_ch(fbv, k));
      chk_cell(12, CH_SPACE);
    end
    ana <= 16'(rnd());
    show(SRC_ANA_VAL, 32'h000c0101);
    for (int k = 0; k < 6; k++) chk_cell(k, val_ch(ana, k));
    cal <= '{month: 4'(1 + rnd() % 12), day: 5'(1 + rnd() % 28),
             year: 14'(2000 + rnd() % 100), hour: 5'(rnd() % 24), minute: 6'(rnd() % 60)};
    show(SRC_DATE, 32'h000c0301);
    exp_s = '{dg(cal.month, 10), dg(cal.month, 1), CH_SLASH, dg(cal.day, 10),
              dg(cal.day, 1), CH_SLASH, dg(cal.year, 1000), dg(cal.year, 100),
              dg(cal.year, 10), dg(cal.year, 1), CH_SPACE, CH_SPACE};
    chk_span(24, 12);
    show(SRC_TIME, 32'h000c0101);
    exp_s[0] = dg(cal.hour, 10);
    exp_s[1] = dg(cal.hour, 1);
    exp_s[2] = CH_COLON;
    exp_s[3] = dg(cal.minute, 10);
    exp_s[4] = dg(cal.minute, 1);
    chk_span(0, 5);
    for (int t = 0; t < 2; t++) begin
      ts <= t[0];
      show(SRC_TS, 32'h000c0101);
      exp_s[0] = CH_O;
      exp_s[1] = t ? CH_N : CH_F;
      exp_s[2] = t ? CH_SPACE : CH_F;
      chk_span(0, 3);
    end
    apb(1'b1, OFS_BAR, 32'h0064ff9c);
    for (int t = 0; t < 3; t++) begin
      ana <= (t == 0) ? 16'hff00 : (t == 1) ? 16'h0200 : 16'(rnd() % 200 - 100);
      show(SRC_ANA_BAR, 32'h000c0101);
      v = (t == 0) ? 0 : (t == 1) ? 12 : (int'($signed(ana)) + 100) * 12 / 200;
      for (int k = 0; k < 12; k++) chk_cell(k, (k < v) ? CH_BAR : CH_SPACE);
    end
    // Flash then scroll, 8 ticks each; checks sit mid-phase, clear of both edges
    apb(1'b1, OFS_TIME, 32'h00000808);
    for (int m = 1; m < 3; m++) begin
      apb(1'b1, OFS_CTRL, 32'h00000501 | 32'(m << 4));
      en <= 1'b0;
      repeat (2) @(posedge clk);
      en <= 1'b1;
      repeat (289) @(posedge clk);
      rd_chk(OFS_STAT, (m == 1) ? 32'h00000001 : 32'h00000103);
      chk_cell(0, (m == 1) ? CH_SPACE : 8'h42);
      repeat (160) @(posedge clk);
      rd_chk(OFS_STAT, (m == 1) ? 32'h00000003 : 32'h00000203);
      chk_cell(0, (m == 1) ? 8'h41 : 8'h43);
    end
    show(SRC_STRING, 32'h000c0101);
    for (int t = 0; t < 2; t++) begin
      ow <= '{wr: 1'b1, free: 1'b0, addr: 6'h00, num: t ? 4'h9 : 4'h3, ch: 8'h5a};
      // Held a whole sweep, so one write meets the sweep at cell 0
      repeat (48) @(posedge clk);
      ow.wr <= 1'b0;
      repeat (120) @(posedge clk);
      chk_cell(0, t ? 8'h5a : 8'h41);
    end
    end_sim();
  end
endmodule : testbench
